// >>> hdl/fieldbus_pkg.sv
// constants, memory map and state codes of the field bus job sequencer
// assumes a 100 MHz clock and a 32-bit sequencer port on the shared job memory
package fieldbus_pkg;
  localparam int CLK_NS       = 10;
  localparam int JOB16_NS     = 4000;
  localparam int JOB32_NS     = 6000;
  localparam int CYCLE_MIN_NS = 50000;
  localparam int CYCLE_MAX_NS = 1000000;

  // longest times round down to whole cycles
  localparam logic [9:0]  JOB16_CYC     = 10'(JOB16_NS / CLK_NS);
  localparam logic [9:0]  JOB32_CYC     = 10'(JOB32_NS / CLK_NS);
  localparam logic [16:0] CYCLE_MIN_CYC = 17'((CYCLE_MIN_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [16:0] CYCLE_MAX_CYC = 17'(CYCLE_MAX_NS / CLK_NS);

  localparam logic [7:0] JOB_LAST = 8'hF9;

  localparam int MEM_AW = 10;
  localparam int MEM_DW = 32;
  localparam logic [9:0] JOB_BASE = 10'h000;
  localparam logic [9:0] OUT_BASE = 10'h100;
  localparam logic [9:0] IN_BASE  = 10'h200;

  // job table entry layout
  localparam int ENT_VALID_BIT = 31;
  localparam int ENT_WIDE_BIT  = 16;
  localparam int ENT_SLOT_LSB  = 8;
  localparam int ENT_NODE_LSB  = 0;

  localparam int LINK_W       = 16;
  localparam int TX_W         = 17;
  localparam int TX_ADDR_FLAG = 16;
  localparam int FIFO_DEPTH   = 8;

  typedef enum logic [7:0] {
    ST_IDLE   = 8'h01,
    ST_FETCH  = 8'h02,
    ST_DECODE = 8'h04,
    ST_LOAD   = 8'h08,
    ST_SEND   = 8'h10,
    ST_WAIT   = 8'h20,
    ST_STORE  = 8'h40,
    ST_NEXT   = 8'h80
  } seq_state_t;
endpackage

// >>> hdl/tx_fifo.sv
// flip-flop FIFO with valid/ready on both sides
// assumes both sides on one clock; full and empty come from an occupancy count
`timescale 1ns/10ps
module tx_fifo #(
  parameter int W     = 17,
  parameter int DEPTH = 8
) (
  input  wire logic         i_clk,
  input  wire logic         i_srst,
  input  wire logic         i_valid,
  output logic              o_ready,
  input  wire logic [W-1:0] i_data,
  output logic              o_valid,
  input  wire logic         i_ready,
  output logic [W-1:0]      o_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  logic          push;
  logic          pop;

  assign o_ready = (count != (AW+1)'(DEPTH));
  assign o_valid = (count != '0);
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;
  assign o_data  = mem[rd_ptr];

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// >>> hdl/fieldbus_job_sequencer.sv
// job table sequencer of a field bus master: walks the table once per bus cycle
// assumes a true dual-port shared job memory with one cycle read latency, and
// ring transmit/receive logic on the same clock
// Functional notes
// - all bus traffic passes through the shared job memory port
// - memory holds job table plus per-slot outgoing and incoming words
// - several entries may name one node; no uniqueness is enforced
// - up to 250 entries, each sends one addressed telegram
// - table walk runs by itself once enabled, no host action
// - a 16-bit job completes within 4 us
// - a 32-bit job completes within 6 us
// - each valid entry before the first invalid one, up to entry 249, is serviced once per walk; a walk starts only at a cycle start while idle
// - bus cycle period is clamped to 0.05 .. 1 ms
// - master transmit feeds ring, replies arrive on receive, fixed timing
// - node address comes from the entry, not from ring position
`timescale 1ns/10ps
module fieldbus_job_sequencer #(
  parameter logic [16:0] CYCLE_MIN_CYC = fieldbus_pkg::CYCLE_MIN_CYC,
  parameter logic [16:0] CYCLE_MAX_CYC = fieldbus_pkg::CYCLE_MAX_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic        i_enable,
  input  wire logic [16:0] i_cycle_period,
  output logic [9:0]       o_mem_addr,
  output logic             o_mem_rd,
  output logic             o_mem_wr,
  output logic [31:0]      o_mem_wdata,
  input  wire logic [31:0] i_mem_rdata,
  output logic             o_tx_valid,
  output logic [16:0]      o_tx_data,
  input  wire logic        i_tx_ready,
  input  wire logic        i_rx_valid,
  input  wire logic [15:0] i_rx_data,
  output logic             o_cycle_start,
  output logic             o_busy,
  output logic             o_job_timeout,
  output logic             o_overrun,
  output logic [7:0]       o_job_index
);
  fieldbus_pkg::seq_state_t state;
  logic [16:0] cyc_cnt;
  logic [16:0] cur_period;
  logic [16:0] clamped;
  logic        tick;
  logic [7:0]  idx;
  logic [7:0]  node;
  logic [7:0]  slot;
  logic        wide;
  logic [31:0] out_word;
  logic [31:0] in_word;
  logic [1:0]  tx_cnt;
  logic        rx_cnt;
  logic [9:0]  timer;
  logic [9:0]  limit;
  logic        deadline;
  logic        fifo_ready;
  logic        push;
  logic [16:0] push_data;
  logic        last_tx;

  // period is taken only at a cycle boundary so a cycle never ends early
  always_comb begin
    clamped = i_cycle_period;
    if (i_cycle_period < CYCLE_MIN_CYC) begin
      clamped = CYCLE_MIN_CYC;
    end else if (i_cycle_period > CYCLE_MAX_CYC) begin
      clamped = CYCLE_MAX_CYC;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cyc_cnt    <= '0;
      cur_period <= CYCLE_MAX_CYC;
      tick       <= 1'b0;
    end else if (cyc_cnt == cur_period - 17'h00001) begin
      cyc_cnt    <= '0;
      cur_period <= clamped;
      tick       <= 1'b1;
    end else begin
      cyc_cnt <= cyc_cnt + 17'h00001;
      tick    <= 1'b0;
    end
  end

  assign o_cycle_start = tick;
  assign o_busy        = (state != fieldbus_pkg::ST_IDLE);
  assign o_job_index   = idx;

  assign limit    = wide ? fieldbus_pkg::JOB32_CYC : fieldbus_pkg::JOB16_CYC;
  assign deadline = (timer >= limit - 10'h002);

  always_comb begin
    push_data = {1'b0, out_word[15:0]};
    if (tx_cnt == 2'h0) begin
      push_data = {1'b1, 8'h00, node};
    end else if (tx_cnt == 2'h2) begin
      push_data = {1'b0, out_word[31:16]};
    end
  end
  assign push    = (state == fieldbus_pkg::ST_SEND) && !deadline;
  assign last_tx = (tx_cnt == (wide ? 2'h2 : 2'h1));

  // shared job memory port; the other port belongs to the host
  always_comb begin
    o_mem_rd    = 1'b0;
    o_mem_wr    = 1'b0;
    o_mem_addr  = fieldbus_pkg::JOB_BASE + {2'h0, idx};
    o_mem_wdata = in_word;
    unique case (state)
      fieldbus_pkg::ST_FETCH: begin
        o_mem_rd = 1'b1;
      end
      fieldbus_pkg::ST_DECODE: begin
        o_mem_rd   = i_mem_rdata[fieldbus_pkg::ENT_VALID_BIT];
        o_mem_addr = fieldbus_pkg::OUT_BASE +
                     {2'h0, i_mem_rdata[fieldbus_pkg::ENT_SLOT_LSB +: 8]};
      end
      fieldbus_pkg::ST_STORE: begin
        o_mem_wr   = 1'b1;
        o_mem_addr = fieldbus_pkg::IN_BASE + {2'h0, slot};
      end
      fieldbus_pkg::ST_IDLE, fieldbus_pkg::ST_LOAD, fieldbus_pkg::ST_SEND,
      fieldbus_pkg::ST_WAIT, fieldbus_pkg::ST_NEXT: begin
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state    <= fieldbus_pkg::ST_IDLE;
      idx      <= '0;
      node     <= '0;
      slot     <= '0;
      wide     <= 1'b0;
      out_word <= '0;
      in_word  <= '0;
      tx_cnt   <= '0;
      rx_cnt   <= 1'b0;
    end else begin
      unique case (state)
        fieldbus_pkg::ST_IDLE: begin
          if (tick && i_enable) begin
            idx   <= '0;
            state <= fieldbus_pkg::ST_FETCH;
          end
        end
        fieldbus_pkg::ST_FETCH: begin
          wide  <= 1'b0;
          state <= fieldbus_pkg::ST_DECODE;
        end
        fieldbus_pkg::ST_DECODE: begin
          // nodes may own several entries and appear in any order
          if (i_mem_rdata[fieldbus_pkg::ENT_VALID_BIT]) begin
            node  <= i_mem_rdata[fieldbus_pkg::ENT_NODE_LSB +: 8];
            slot  <= i_mem_rdata[fieldbus_pkg::ENT_SLOT_LSB +: 8];
            wide  <= i_mem_rdata[fieldbus_pkg::ENT_WIDE_BIT];
            state <= fieldbus_pkg::ST_LOAD;
          end else begin
            state <= fieldbus_pkg::ST_IDLE;
          end
        end
        fieldbus_pkg::ST_LOAD: begin
          out_word <= i_mem_rdata;
          in_word  <= '0;
          tx_cnt   <= '0;
          state    <= fieldbus_pkg::ST_SEND;
        end
        fieldbus_pkg::ST_SEND: begin
          // a truncated telegram lacks its data word; the job is then dropped
          if (deadline) begin
            state <= fieldbus_pkg::ST_NEXT;
          end else if (fifo_ready) begin
            tx_cnt <= tx_cnt + 2'h1;
            if (last_tx) begin
              rx_cnt <= 1'b0;
              state  <= fieldbus_pkg::ST_WAIT;
            end
          end
        end
        fieldbus_pkg::ST_WAIT: begin
          if (deadline) begin
            state <= fieldbus_pkg::ST_NEXT;
          end else if (i_rx_valid) begin
            rx_cnt <= 1'b1;
            if (rx_cnt) begin
              in_word[31:16] <= i_rx_data;
            end else begin
              in_word[15:0] <= i_rx_data;
            end
            if (rx_cnt || !wide) begin
              state <= fieldbus_pkg::ST_STORE;
            end
          end
        end
        fieldbus_pkg::ST_STORE: begin
          state <= fieldbus_pkg::ST_NEXT;
        end
        fieldbus_pkg::ST_NEXT: begin
          idx <= idx + 8'h01;
          if (idx == fieldbus_pkg::JOB_LAST) begin
            state <= fieldbus_pkg::ST_IDLE;
          end else begin
            state <= fieldbus_pkg::ST_FETCH;
          end
        end
      endcase
    end
  end

  // job timer restarts at every fetch
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      timer <= '0;
    end else if (state == fieldbus_pkg::ST_FETCH) begin
      timer <= 10'h001;
    end else if (state != fieldbus_pkg::ST_IDLE && timer != 10'h3FF) begin
      timer <= timer + 10'h001;
    end
  end

  // a cycle start during a walk is skipped rather than restarting the table
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_job_timeout <= 1'b0;
      o_overrun     <= 1'b0;
    end else begin
      o_job_timeout <= deadline && (state == fieldbus_pkg::ST_SEND ||
                                    state == fieldbus_pkg::ST_WAIT);
      o_overrun     <= tick && (state != fieldbus_pkg::ST_IDLE);
    end
  end

  tx_fifo #(
    .W     (fieldbus_pkg::TX_W),
    .DEPTH (fieldbus_pkg::FIFO_DEPTH)
  ) u_tx_fifo (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_valid (push),
    .o_ready (fifo_ready),
    .i_data  (push_data),
    .o_valid (o_tx_valid),
    .i_ready (i_tx_ready),
    .o_data  (o_tx_data)
  );

  // helper: length of the last bus cycle
  logic [16:0] gap;
  logic        seen;
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      gap  <= '0;
      seen <= 1'b0;
    end else begin
      gap  <= tick ? 17'h00001 : gap + 17'h00001;
      seen <= seen | tick;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  sequence s_valid_entry;
    state == fieldbus_pkg::ST_DECODE && i_mem_rdata[fieldbus_pkg::ENT_VALID_BIT];
  endsequence

  a_cycle_len_range: assert property (
    tick && seen |-> gap >= CYCLE_MIN_CYC && gap <= CYCLE_MAX_CYC)
    else $error("bus cycle length out of range");
  a_walk_from_zero: assert property (
    state == fieldbus_pkg::ST_IDLE && tick && i_enable |=>
      state == fieldbus_pkg::ST_FETCH && idx == 8'h00)
    else $error("walk did not start at entry zero");
  a_walk_stops_idle: assert property (
    state == fieldbus_pkg::ST_DECODE && !i_mem_rdata[fieldbus_pkg::ENT_VALID_BIT] |=>
      state == fieldbus_pkg::ST_IDLE)
    else $error("walk went on past an invalid entry");
  a_autonomous_read: assert property (
    state == fieldbus_pkg::ST_IDLE && tick && i_enable |=> o_mem_rd)
    else $error("table walk did not read the job table");
  a_addr_telegram: assert property (
    s_valid_entry ##2 state == fieldbus_pkg::ST_SEND |->
      push_data == {1'b1, 8'h00, $past(i_mem_rdata[7:0], 2)})
    else $error("telegram address differs from entry node");
  a_out_word_read: assert property (
    s_valid_entry |-> o_mem_rd &&
      o_mem_addr == fieldbus_pkg::OUT_BASE + {2'h0, i_mem_rdata[15:8]})
    else $error("outgoing word not read from the entry slot");
  a_job16_bound: assert property (
    !wide && state != fieldbus_pkg::ST_IDLE |-> timer <= fieldbus_pkg::JOB16_CYC)
    else $error("16-bit job exceeded its time");
  a_job32_bound: assert property (
    wide && state != fieldbus_pkg::ST_IDLE |-> timer <= fieldbus_pkg::JOB32_CYC)
    else $error("32-bit job exceeded its time");
  a_table_limit: assert property (
    state == fieldbus_pkg::ST_NEXT && idx == fieldbus_pkg::JOB_LAST |=>
      state == fieldbus_pkg::ST_IDLE)
    else $error("walk went past the last table entry");
  a_once_per_cycle: assert property (
    tick && state != fieldbus_pkg::ST_IDLE |=> idx >= $past(idx) && o_overrun)
    else $error("walk restarted within a bus cycle");
endmodule

// >>> verification/ring_node_model.sv
// far-side model of the slave ring: takes each telegram off the master and answers it
// assumes address words carry bit 16; a node address with bit 7 set holds 32-bit data
`timescale 1ns/10ps
module ring_node_model (
  input  wire logic        i_clk,
  input  wire logic        i_stall,
  input  wire logic        i_mute,
  input  wire logic        i_tx_valid,
  input  wire logic [16:0] i_tx_data,
  output logic             o_tx_ready,
  output logic             o_rx_valid,
  output logic [15:0]      o_rx_data,
  output logic [7:0]       o_node_seen,
  output logic [15:0]      o_telegrams
);
  logic [16:0] words[$];

  // ready moves only at the falling edge
  always @(negedge i_clk) begin
    o_tx_ready <= !i_stall;
  end

  // a word is taken at the rising edge at which the master pops it, before its fifo moves on
  always @(posedge i_clk) begin
    if (i_tx_valid === 1'b1 && o_tx_ready === 1'b1) words.push_back(i_tx_data);
  end

  task automatic take(output logic [16:0] w);
    while (words.size() == 0) @(negedge i_clk);
    w = words.pop_front();
  endtask

  task automatic reply(input logic [15:0] w);
    @(negedge i_clk);
    o_rx_valid = 1'b1;
    o_rx_data  = ~w;
    @(negedge i_clk);
    o_rx_valid = 1'b0;
    // released line shows the inverse of its last value
    o_rx_data  = w;
  endtask

  initial begin
    logic [16:0] head;
    logic [16:0] lo;
    logic [16:0] hi;
    o_tx_ready  = 1'b0;
    o_rx_valid  = 1'b0;
    o_rx_data   = 16'h5A5A;
    o_node_seen = 8'h00;
    o_telegrams = 16'h0000;
    forever begin
      take(head);
      if (head[16]) begin
        take(lo);
        hi = 17'h00000;
        if (head[7]) take(hi);
        o_node_seen = head[7:0];
        o_telegrams = o_telegrams + 16'h0001;
        repeat (3) @(negedge i_clk);
        // a muted node stays silent so the master must give up on the job
        if (!i_mute) begin
          reply(lo[15:0]);
          if (head[7]) reply(hi[15:0]);
        end
      end
    end
  end
endmodule

// >>> verification/fieldbus_job_sequencer_tb_top.sv
// self-checking bench of the job sequencer with a shared memory model and a ring model
// assumes the memory answers a read strobe on the cycle after it; inputs move at falling edges
`timescale 1ns/10ps
module fieldbus_job_sequencer_tb_top;
  typedef struct packed {
    logic [7:0]  node;
    logic [7:0]  slot;
    logic [31:0] out;
  } row_t;
  localparam row_t ROWS [5] = '{
    '{8'h05, 8'h03, 32'h12345678}, '{8'h81, 8'h00, 32'hDEADBEEF},
    '{8'h02, 8'h07, 32'h0000FFFF}, '{8'h05, 8'h09, 32'hFFFF0001},
    '{8'hC0, 8'hFF, 32'h80000001}};
  logic        clk, srst, enable, stall, stall_on, mute, rd_q;
  logic [16:0] cycle_period, tx_data;
  logic [9:0]  mem_addr, rd_addr;
  logic        mem_rd, mem_wr, tx_valid, tx_ready, rx_valid;
  logic        cycle_start, busy, job_timeout, overrun;
  logic [31:0] mem_wdata, mem_rdata;
  logic [15:0] rx_data, telegrams;
  logic [7:0]  job_index, node_seen;
  logic [31:0] mem [1024];
  int          cyc, n_wr, t_fetch, lim, n_errors, compares, k, w0;

  fieldbus_job_sequencer #(.CYCLE_MIN_CYC(17'h00032), .CYCLE_MAX_CYC(17'h01F40)) dut (
    .i_clk(clk), .i_srst(srst), .i_enable(enable), .i_cycle_period(cycle_period),
    .o_mem_addr(mem_addr), .o_mem_rd(mem_rd), .o_mem_wr(mem_wr), .o_mem_wdata(mem_wdata),
    .i_mem_rdata(mem_rdata), .o_tx_valid(tx_valid), .o_tx_data(tx_data),
    .i_tx_ready(tx_ready), .i_rx_valid(rx_valid), .i_rx_data(rx_data),
    .o_cycle_start(cycle_start), .o_busy(busy), .o_job_timeout(job_timeout),
    .o_overrun(overrun), .o_job_index(job_index));

  ring_node_model ring (
    .i_clk(clk), .i_stall(stall), .i_mute(mute), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
    .o_tx_ready(tx_ready), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
    .o_node_seen(node_seen), .o_telegrams(telegrams));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // read strobe and address are taken at the rising edge, like a synchronous ram port
  always @(posedge clk) begin
    rd_q    <= (mem_rd === 1'b1);
    rd_addr <= mem_addr;
  end

  // memory answers one cycle late; an idle read bus toggles so stale data is never mistaken
  always @(negedge clk) begin
    mem_rdata <= rd_q ? mem[rd_addr] : ~mem_rdata;
    cyc       <= cyc + 1;
    stall     <= stall_on & cyc[1];
    if (mem_rd === 1'b1 && mem_addr[9:8] === 2'b00) begin
      t_fetch <= cyc;
      lim     <= mem[mem_addr][16] ? 600 : 400;
    end
    if (mem_wr === 1'b1) begin
      mem[mem_addr] <= mem_wdata;
      n_wr          <= n_wr + 1;
      check("job_time", 32'(cyc - t_fetch <= lim), 32'h00000001);
    end
  end

  function automatic logic [31:0] ent(input logic [7:0] node, input logic [7:0] slot);
    return {1'b1, 14'h0000, node[7], slot, node};
  endfunction

  function automatic logic [31:0] inc(input logic [31:0] out, input logic wide);
    return {wide ? ~out[31:16] : 16'h0000, ~out[15:0]};
  endfunction

  task automatic wait_start;
    k = 0;
    while (cycle_start !== 1'b1 && k < 9000) begin
      @(negedge clk);
      k++;
    end
    check("cycle_start", cycle_start, 32'h00000001);
  endtask

  task automatic wait_idle;
    k = 0;
    @(negedge clk);
    while (busy !== 1'b0 && k < 9000) begin
      @(negedge clk);
      k++;
    end
    check("busy_end", busy, 32'h00000000);
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // four bus cycles of 8000 clocks plus margin
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    print_verdict();
  end

  initial begin
    {srst, enable, stall, stall_on, mute, rd_q} = 6'b110000;
    cyc = 0;
    n_wr = 0;
    t_fetch = 0;
    lim = 400;
    n_errors = 0;
    compares = 0;
    cycle_period = 17'h01F40;
    rd_addr = 10'h000;
    mem_rdata = 32'h00000000;
    for (int i = 0; i < 1024; i++) mem[i] = 32'h00000000;
    for (int i = 0; i < 5; i++) begin
      mem[i] = ent(ROWS[i].node, ROWS[i].slot);
      mem[10'h100 + 10'(ROWS[i].slot)] = ROWS[i].out;
    end
    mem[6] = ent(8'h10, 8'h10);
    repeat (10) @(negedge clk);
    check("reset_busy", {busy, mem_rd, mem_wr, tx_valid, job_index}, 32'h00000000);
    srst = 1'b0;
    $display("reset test done");
    w0 = n_wr;
    wait_start();
    wait_idle();
    check("row_writes", n_wr - w0, 32'h00000005);
    for (int i = 0; i < 5; i++)
      check("incoming", mem[10'h200 + 10'(ROWS[i].slot)], inc(ROWS[i].out, ROWS[i].node[7]));
    $display("row test done");
    for (int i = 0; i < 251; i++) begin
      mem[i] = ent(8'(i), 8'(i));
      mem[10'h100 + 10'(i)] = 32'(i) * 32'h00010003;
      mem[10'h200 + 10'(i)] = 32'h00000000;
    end
    stall_on = 1'b1;
    w0 = n_wr;
    wait_start();
    wait_idle();
    check("full_writes", n_wr - w0, 32'h000000FA);
    check("last_node", node_seen, 32'h000000F9);
    check("slot_250", mem[10'h2FA], 32'h00000000);
    for (int i = 0; i < 250; i++)
      check("incoming", mem[10'h200 + 10'(i)], inc(32'(i) * 32'h00010003, i >= 128));
    $display("full table test done");
    stall_on = 1'b0;
    mute = 1'b1;
    mem[0] = ent(8'h81, 8'h20);
    mem[1] = 32'h00000000;
    w0 = n_wr;
    wait_start();
    k = 0;
    while (job_timeout !== 1'b1 && k < 700) begin
      @(negedge clk);
      k++;
    end
    check("timeout", job_timeout, 32'h00000001);
    check("timeout_time", 32'(k <= 601), 32'h00000001);
    check("timeout_writes", n_wr - w0, 32'h00000000);
    $display("timeout test done");
    wait_idle();
    cycle_period = 17'h0000A;
    wait_start();
    k = 0;
    while (overrun !== 1'b1 && k < 200) begin
      @(negedge clk);
      k++;
    end
    check("overrun", overrun, 32'h00000001);
    mem[0] = 32'h00000000;
    mute = 1'b0;
    wait_idle();
    enable = 1'b0;
    wait_start();
    @(negedge clk);
    check("disabled_busy", {busy, mem_rd}, 32'h00000000);
    enable = 1'b1;
    wait_start();
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (cycle_start !== 1'b1 && k < 200);
    check("period", k, 32'h00000032);
    $display("overrun and period test done");
    print_verdict();
  end
endmodule
